// [lpst_top.sv]
// watchdog and wake-up timer with their control registers
// assumes synchronous cpu state inputs and a plain register port
`timescale 1ns/1ps
`include "lpst_map.svh"

module lpst_top #(
   parameter int LSRC_DIV = `LPST_CLK_HZ / `LPST_LSRC_HZ
)(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              rst_por,
   // configuration and cpu state
   input  wire logic              config_watchdog_disable,
   input  wire logic              cpu_idle,
   input  wire logic              cpu_power_down,
   input  wire logic              global_interrupt_enable,
   // register port
   input  wire lpst_pkg::lpst_addr_t reg_addr,
   input  wire lpst_pkg::lpst_byte_t reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output lpst_pkg::lpst_byte_t   reg_rdata,
   // system events
   output logic                   watchdog_reset_req,
   output logic                   wakeup_req,
   output logic                   wakeup_irq
);
   import lpst_pkg::*;

   localparam int DW = $clog2(LSRC_DIV);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic          wd_en_r;
   logic          wd_en_nxt;
   logic          wd_ris_r;
   logic          wd_ris_nxt;
   logic          wd_flag_r;
   logic          wd_flag_nxt;
   lpst_psel_t    wd_psel_r;
   lpst_psel_t    wd_psel_nxt;
   logic          wk_en_r;
   logic          wk_en_nxt;
   logic          wk_flag_r;
   logic          wk_flag_nxt;
   lpst_psel_t    wk_psel_r;
   lpst_psel_t    wk_psel_nxt;
   logic          wk_ie_r;
   logic          wk_ie_nxt;

   logic [DW-1:0] lsrc_cnt_r;
   logic [DW-1:0] lsrc_cnt_nxt;
   logic          sleep_d_r;
   logic          sleep_d_nxt;
   logic          rst_req_r;
   logic          rst_req_nxt;
   logic          wake_r;
   logic          wake_nxt;
   logic          irq_r;
   logic          irq_nxt;
   lpst_byte_t    rdata_r;
   lpst_byte_t    rdata_nxt;

   logic          lsrc_tick;
   logic          sleep;
   logic          sleep_edge;
   logic          wd_wr;
   logic          wk_wr;
   logic          xie_wr;

   lpst_tmr_if    wd_if ();
   lpst_tmr_if    wk_if ();

   // ------------------------------------------------------------
   // prescale lookup
   // ------------------------------------------------------------
   // watchdog divider as a power of two
   function automatic lpst_shift_t wd_shift(input lpst_psel_t sel);
      lpst_shift_t s;
      unique case (sel)
         3'h0: s = 4'h0;
         3'h1: s = 4'h1;
         3'h2: s = 4'h3;
         3'h3: s = 4'h4;
         3'h4: s = 4'h5;
         3'h5: s = 4'h6;
         3'h6: s = 4'h7;
         3'h7: s = 4'h8;
      endcase
      return s;
   endfunction : wd_shift

   // wake-up divider as a power of two
   function automatic lpst_shift_t wk_shift(input lpst_psel_t sel);
      lpst_shift_t s;
      unique case (sel)
         3'h0: s = 4'h0;
         3'h1: s = 4'h2;
         3'h2: s = 4'h3;
         3'h3: s = 4'h5;
         3'h4: s = 4'h6;
         3'h5: s = 4'h8;
         3'h6: s = 4'h9;
         3'h7: s = 4'hA;
      endcase
      return s;
   endfunction : wk_shift

   // ------------------------------------------------------------
   // decode and timer hookup
   // ------------------------------------------------------------
   // write decode, low-speed rc tick and sleep edge
   assign wd_wr      = reg_wr && (reg_addr == `LPST_WDCTL_OFF);
   assign wk_wr      = reg_wr && (reg_addr == `LPST_WKCON_OFF);
   assign xie_wr     = reg_wr && (reg_addr == `LPST_XIE_OFF);
   assign lsrc_tick  = (lsrc_cnt_r == DW'(LSRC_DIV - 1));
   assign sleep      = cpu_idle || cpu_power_down;
   assign sleep_edge = sleep ^ sleep_d_r;

   // watchdog counter controls
   assign wd_if.tick  = lsrc_tick;
   assign wd_if.run   = wd_en_r && (!sleep || wd_ris_r);
   assign wd_if.clear = (wd_wr && reg_wdata[`LPST_WD_CLR_BIT])
                        || sleep_edge;
   assign wd_if.shift = wd_shift(wd_psel_r);

   // wake-up counter controls, no sleep gating
   assign wk_if.tick  = lsrc_tick;
   assign wk_if.run   = wk_en_r;
   assign wk_if.clear = wk_wr && reg_wdata[`LPST_WK_CLR_BIT];
   assign wk_if.shift = wk_shift(wk_psel_r);

   lpst_timer #(.PW(`LPST_PRESC_W)) u_wd_timer (
      .clk (clk),
      .rst (rst),
      .tif (wd_if.tmr)
   );

   lpst_timer #(.PW(`LPST_PRESC_W)) u_wk_timer (
      .clk (clk),
      .rst (rst),
      .tif (wk_if.tmr)
   );

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   // software writes, hardware sets win, then reset loading
   always_comb
   begin
      wd_en_nxt   = wd_en_r;
      wd_ris_nxt  = wd_ris_r;
      wd_flag_nxt = wd_flag_r;
      wd_psel_nxt = wd_psel_r;
      wk_en_nxt   = wk_en_r;
      wk_flag_nxt = wk_flag_r;
      wk_psel_nxt = wk_psel_r;
      wk_ie_nxt   = wk_ie_r;
      if (wd_wr)
      begin
         wd_en_nxt   = reg_wdata[`LPST_WD_EN_BIT];
         wd_ris_nxt  = reg_wdata[`LPST_WD_RIS_BIT];
         wd_flag_nxt = reg_wdata[`LPST_WD_FLAG_BIT];
         wd_psel_nxt = reg_wdata[`LPST_PSEL_MSB:`LPST_PSEL_LSB];
      end
      if (wk_wr)
      begin
         wk_en_nxt   = reg_wdata[`LPST_WK_EN_BIT];
         wk_psel_nxt = reg_wdata[`LPST_PSEL_MSB:`LPST_PSEL_LSB];
         if (!reg_wdata[`LPST_WK_FLAG_BIT])
         begin
            wk_flag_nxt = 1'b0;
         end
      end
      if (xie_wr)
      begin
         wk_ie_nxt = reg_wdata[`LPST_XIE_WK_BIT];
      end
      if (wd_if.timeout)
      begin
         wd_flag_nxt = 1'b1;
      end
      if (wk_if.timeout)
      begin
         wk_flag_nxt = 1'b1;
      end
      if (rst)
      begin
         wd_en_nxt   = ~config_watchdog_disable;
         wk_en_nxt   = 1'(`LPST_WKCON_RST >> `LPST_WK_EN_BIT);
         wk_flag_nxt = 1'b0;
         wk_psel_nxt = `LPST_PSEL_RST;
         wk_ie_nxt   = 1'b0;
         if (rst_por)
         begin
            wd_ris_nxt  = 1'b0;
            wd_psel_nxt = `LPST_PSEL_RST;
            wd_flag_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      wd_en_r   <= wd_en_nxt;
      wd_ris_r  <= wd_ris_nxt;
      wd_flag_r <= wd_flag_nxt;
      wd_psel_r <= wd_psel_nxt;
      wk_en_r   <= wk_en_nxt;
      wk_flag_r <= wk_flag_nxt;
      wk_psel_r <= wk_psel_nxt;
      wk_ie_r   <= wk_ie_nxt;
   end

   // ------------------------------------------------------------
   // divider, events and read port
   // ------------------------------------------------------------
   // rc tick divider, registered events, one-cycle read data
   always_comb
   begin
      lsrc_cnt_nxt = lsrc_tick ? '0 : DW'(lsrc_cnt_r + 1'b1);
      sleep_d_nxt  = sleep;
      rst_req_nxt  = wd_if.timeout;
      wake_nxt     = wk_if.timeout;
      irq_nxt      = wk_flag_r && wk_ie_r
                     && global_interrupt_enable;
      rdata_nxt    = '0;
      if (reg_rd)
      begin
         unique case (reg_addr)
            `LPST_WDCTL_OFF: rdata_nxt = {wd_en_r, 2'h0, wd_ris_r, wd_flag_r, wd_psel_r};
            `LPST_WKCON_OFF: rdata_nxt = {wk_en_r, 1'b0, wk_flag_r, 2'h0, wk_psel_r};
            `LPST_XIE_OFF:   rdata_nxt = {6'h00, wk_ie_r, 1'b0};
            default:         rdata_nxt = '0;
         endcase
      end
      if (rst)
      begin
         lsrc_cnt_nxt = '0;
         sleep_d_nxt  = 1'b0;
         rst_req_nxt  = 1'b0;
         wake_nxt     = 1'b0;
         irq_nxt      = 1'b0;
         rdata_nxt    = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      lsrc_cnt_r <= lsrc_cnt_nxt;
      sleep_d_r  <= sleep_d_nxt;
      rst_req_r  <= rst_req_nxt;
      wake_r     <= wake_nxt;
      irq_r      <= irq_nxt;
      rdata_r    <= rdata_nxt;
   end

   // outputs straight from flops
   assign reg_rdata          = rdata_r;
   assign watchdog_reset_req = rst_req_r;
   assign wakeup_req         = wake_r;
   assign wakeup_irq         = irq_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_wd_clear_write;
      wd_wr && reg_wdata[`LPST_WD_CLR_BIT];
   endsequence

   sequence s_wk_clear_write;
      wk_wr && reg_wdata[`LPST_WK_CLR_BIT];
   endsequence

   a_wd_clear_zero: assert property (
      s_wd_clear_write |=> wd_if.count == '0)
      else $error("watchdog clear left count");
   a_wd_sleep_halt: assert property (
      (sleep && sleep_d_r && !wd_ris_r && !wd_if.clear) |=> $stable(wd_if.count))
      else $error("watchdog ran in sleep");
   a_wd_sleep_clear: assert property (
      sleep_edge |=> wd_if.count == '0)
      else $error("sleep edge kept count");
   a_wd_flag_reset: assert property (
      wd_if.timeout |=> wd_flag_r && watchdog_reset_req ##1 !watchdog_reset_req)
      else $error("watchdog timeout lost");
   a_wd_por_load: assert property (
      disable iff (1'b0) (rst && rst_por) |=> !wd_flag_r && !wd_ris_r
         && wd_psel_r == '0 && wd_en_r == !$past(config_watchdog_disable))
      else $error("power-on reset load wrong");
   a_wd_warm_keep: assert property (
      disable iff (1'b0) (rst && !rst_por && !wd_if.timeout) |=> $stable(wd_flag_r)
         && $stable(wd_ris_r) && $stable(wd_psel_r))
      else $error("warm reset lost watchdog bits");
   a_wk_clear_self: assert property (
      s_wk_clear_write |=> wk_if.count == '0 && !reg_rdata[`LPST_WK_CLR_BIT])
      else $error("wake-up clear not self-cleared");
   a_wk_wake_irq: assert property (
      (wk_if.timeout && wk_ie_r && global_interrupt_enable && !xie_wr)
         |=> wakeup_req && wk_flag_r ##1 wakeup_irq)
      else $error("wake-up event missing");
   a_wk_irq_gate: assert property (
      wakeup_irq |-> $past(wk_ie_r) && $past(global_interrupt_enable) && $past(wk_flag_r))
      else $error("ungated wake-up interrupt");
   a_wk_flag_sticky: assert property (
      (wk_flag_r && !wk_wr) |=> wk_flag_r)
      else $error("wake-up flag dropped");

endmodule : lpst_top

// [lpst_map.svh]
// register offsets, bit positions, reset values and timing counts
// assumes inclusion by bare name from the package and design files
`ifndef LPST_MAP_SVH
`define LPST_MAP_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LPST_CLK_HZ            40000000
`define LPST_LSRC_HZ           10000
`define LPST_TICKS_PER_TIMEOUT 64
`define LPST_PRESC_W           10

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define LPST_WDCTL_OFF         8'hAA
`define LPST_WKCON_OFF         8'hAB
`define LPST_XIE_OFF           8'hE8

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LPST_WD_EN_BIT         7
`define LPST_WD_CLR_BIT        6
`define LPST_WD_RIS_BIT        4
`define LPST_WD_FLAG_BIT       3
`define LPST_WK_EN_BIT         7
`define LPST_WK_CLR_BIT        6
`define LPST_WK_FLAG_BIT       5
`define LPST_PSEL_MSB          2
`define LPST_PSEL_LSB          0
`define LPST_XIE_WK_BIT        1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LPST_WKCON_RST         8'h00
`define LPST_PSEL_RST          3'h0

`endif

// [lpst_pkg.sv]
// shared types of the low-power supervisor timers
// assumes lpst_map.svh on the include path
`include "lpst_map.svh"

package lpst_pkg;

   typedef logic [7:0] lpst_addr_t;
   typedef logic [7:0] lpst_byte_t;
   typedef logic [2:0] lpst_psel_t;
   typedef logic [3:0] lpst_shift_t;
   typedef logic [$clog2(`LPST_TICKS_PER_TIMEOUT)-1:0] lpst_cnt_t;

endpackage : lpst_pkg

// [lpst_tmr_if.sv]
// link between the control logic and one prescaled tick timer
// assumes lpst_pkg compiled first
`timescale 1ns/1ps

interface lpst_tmr_if;
   import lpst_pkg::*;

   logic        tick;
   logic        run;
   logic        clear;
   lpst_shift_t shift;
   logic        timeout;
   lpst_cnt_t   count;

   modport ctl (output tick, output run, output clear, output shift,
                input timeout, input count);
   modport tmr (input tick, input run, input clear, input shift,
                output timeout, output count);
endinterface : lpst_tmr_if

// [lpst_timer.sv]
// prescaler plus 6-bit tick counter, one per supervisory timer
// assumes tick is a one-cycle enable at the low-speed rc rate
`timescale 1ns/1ps
`include "lpst_map.svh"

module lpst_timer #(
   parameter int PW = `LPST_PRESC_W
)(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control link
   lpst_tmr_if.tmr  tif
);
   import lpst_pkg::*;

   logic [PW-1:0] presc_r;
   logic [PW-1:0] presc_nxt;
   logic [PW-1:0] mask;
   lpst_cnt_t     cnt_r;
   lpst_cnt_t     cnt_nxt;
   logic          ptick;

   // ------------------------------------------------------------
   // prescaler and tick counter
   // ------------------------------------------------------------
   // prescaled tick when the selected low bits are all ones
   always_comb
   begin
      mask      = ~({PW{1'b1}} << tif.shift);
      ptick     = tif.run && tif.tick && ((presc_r & mask) == mask);
      presc_nxt = presc_r;
      cnt_nxt   = cnt_r;
      if (rst || tif.clear)
      begin
         presc_nxt = '0;
         cnt_nxt   = '0;
      end
      else if (tif.run && tif.tick)
      begin
         presc_nxt = PW'(presc_r + 1'b1);
         if (ptick)
         begin
            cnt_nxt = lpst_cnt_t'(cnt_r + 1'b1);
         end
      end
   end

   always_ff @(posedge clk)
   begin
      presc_r <= presc_nxt;
      cnt_r   <= cnt_nxt;
   end

   // wrap after the 64th prescaled tick, a clear beats it
   assign tif.timeout = ptick && (cnt_r == '1) && !tif.clear && !rst;
   assign tif.count   = cnt_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_tmr_step_up: assert property (
      (ptick && !tif.clear && cnt_r != '1) |=> cnt_r == $past(cnt_r) + 1'b1)
      else $error("tick counter did not step");
   a_tmr_wrap_out: assert property (
      tif.timeout |=> cnt_r == '0 && (presc_r & $past(mask)) == '0)
      else $error("timeout without wrap");
   a_tmr_hold_idle: assert property (
      (!tif.run && !tif.clear) |=> $stable(cnt_r) && $stable(presc_r))
      else $error("timer moved while stopped");

endmodule : lpst_timer

// [tb_top.sv]
// self-checking testbench for the low-power supervisor timers
// assumes lpst_pkg and lpst_map.svh compiled first; checkers sit in the design
`timescale 1ns/1ps
`include "lpst_map.svh"

module tb_top;
   import lpst_pkg::*;

   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam int DIV = 2;
   logic       clk;
   logic       rst;
   logic       rst_por;
   logic       config_watchdog_disable;
   logic       cpu_idle;
   logic       cpu_power_down;
   logic       global_interrupt_enable;
   lpst_addr_t reg_addr;
   lpst_byte_t reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   lpst_byte_t reg_rdata;
   logic       watchdog_reset_req;
   logic       wakeup_req;
   logic       wakeup_irq;
   int         errors;
   int         num_checks;
   int         n;
   int         wdd [5] = '{1, 2, 8, 16, 32};
   int         wkd [5] = '{1, 4, 8, 32, 64};

   // short rc divider keeps the long intervals simulable
   lpst_top #(.LSRC_DIV(DIV)) i_dut (
      .clk                     (clk),
      .rst                     (rst),
      .rst_por                 (rst_por),
      .config_watchdog_disable (config_watchdog_disable),
      .cpu_idle                (cpu_idle),
      .cpu_power_down          (cpu_power_down),
      .global_interrupt_enable (global_interrupt_enable),
      .reg_addr                (reg_addr),
      .reg_wdata               (reg_wdata),
      .reg_wr                  (reg_wr),
      .reg_rd                  (reg_rd),
      .reg_rdata               (reg_rdata),
      .watchdog_reset_req      (watchdog_reset_req),
      .wakeup_req              (wakeup_req),
      .wakeup_irq              (wakeup_irq)
   );

   // clock generator
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask : chk

   task automatic wr(input lpst_addr_t a, input lpst_byte_t d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // read data stands in the cycle after the strobe
   task automatic rdchk(input lpst_addr_t a, input lpst_byte_t exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, exp, "read data");
   endtask : rdchk

   // cycles until the selected pulse, or lim if none comes
   task automatic wait_ev(input int sel, input int lim, output int cnt);
      cnt = 0;
      do
      begin
         @(posedge clk);
         #1;
         cnt++;
      end
      while (!((sel == 0 ? watchdog_reset_req : wakeup_req) === 1'b1) && cnt < lim);
   endtask : wait_ev

   // second interval is exact, the first may start mid-tick
   task automatic period(input int sel, input int p);
      int c;
      wait_ev(sel, 2 * p + 20, c);
      wait_ev(sel, p + 20, c);
      chk(c, p, "time-out interval");
   endtask : period

   task automatic do_reset(input logic por, input logic cfg);
      @(posedge clk);
      rst                     <= 1'b1;
      rst_por                 <= por;
      config_watchdog_disable <= cfg;
      repeat (20) @(posedge clk);
      rst     <= 1'b0;
      rst_por <= 1'b0;
   endtask : do_reset

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   // watchdog against a hang
   initial
   begin
      repeat (80000) @(posedge clk);
      errors++;
      $display("unexpected at %0t: run did not finish", $time);
      summarize();
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial
   begin
      rst = 1'b1; rst_por = 1'b1; config_watchdog_disable = 1'b1;
      cpu_idle = 1'b0; cpu_power_down = 1'b0; global_interrupt_enable = 1'b0;
      reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
      errors = 0; num_checks = 0;
      do_reset(1'b1, 1'b1);
      rdchk(`LPST_WDCTL_OFF, 8'h00);
      rdchk(`LPST_WKCON_OFF, 8'h00);
      rdchk(`LPST_XIE_OFF, 8'h00);
      wr(8'h10, 8'hFF);
      rdchk(8'h10, 8'h00);
      wr(`LPST_WDCTL_OFF, 8'h7F);
      rdchk(`LPST_WDCTL_OFF, 8'h1F);
      wr(`LPST_WKCON_OFF, 8'h7F);
      rdchk(`LPST_WKCON_OFF, 8'h07);
      $display("test registers done");

      // watchdog interval for prescales 0 to 4 and the reset flag
      for (int c = 0; c < 5; c++)
      begin
         wr(`LPST_WDCTL_OFF, 8'hC0 | c);
         period(0, 64 * wdd[c] * DIV);
         rdchk(`LPST_WDCTL_OFF, 8'h88 | c);
      end
      wr(`LPST_WDCTL_OFF, 8'h00);
      wait_ev(0, 400, n);
      chk(n, 400, "disabled watchdog fired");
      $display("test watchdog timing done");

      // sleep behaviour and clearing
      wr(`LPST_WDCTL_OFF, 8'hC0);
      cpu_idle <= 1'b1;
      wait_ev(0, 400, n);
      chk(n, 400, "watchdog ran in sleep");
      wr(`LPST_WDCTL_OFF, 8'h90);
      wait_ev(0, 300, n);
      chk(n < 300, 1, "watchdog halted in sleep");
      repeat (60) @(posedge clk);
      cpu_idle <= 1'b0;
      wait_ev(0, 200, n);
      chk(n > 120, 1, "count kept on wake");
      repeat (60) @(posedge clk);
      cpu_power_down <= 1'b1;
      wait_ev(0, 200, n);
      chk(n > 120, 1, "count kept on entry");
      repeat (60) @(posedge clk);
      wr(`LPST_WDCTL_OFF, 8'hD0);
      wait_ev(0, 200, n);
      chk(n > 120, 1, "clear ignored");
      wr(`LPST_WDCTL_OFF, 8'h00);
      $display("test watchdog sleep done");

      // wake-up timer runs in power down
      for (int c = 0; c < 5; c++)
      begin
         wr(`LPST_WKCON_OFF, 8'h40);
         wr(`LPST_WKCON_OFF, 8'h80 | c);
         period(1, 64 * wkd[c] * DIV);
         rdchk(`LPST_WKCON_OFF, 8'hA0 | c);
      end
      wr(`LPST_XIE_OFF, 8'hFF);
      rdchk(`LPST_XIE_OFF, 8'h02);
      repeat (2) @(posedge clk);
      #1 chk(wakeup_irq, 1'b0, "irq without global enable");
      @(posedge clk) global_interrupt_enable <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(wakeup_irq, 1'b1, "irq missing");
      wr(`LPST_XIE_OFF, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk(wakeup_irq, 1'b0, "irq not gated");
      wr(`LPST_XIE_OFF, 8'h02);
      wr(`LPST_WKCON_OFF, 8'hA4);
      rdchk(`LPST_WKCON_OFF, 8'hA4);
      wr(`LPST_WKCON_OFF, 8'h84);
      rdchk(`LPST_WKCON_OFF, 8'h84);
      repeat (2) @(posedge clk);
      #1 chk(wakeup_irq, 1'b0, "irq after flag clear");
      wr(`LPST_WKCON_OFF, 8'h40);
      wr(`LPST_WKCON_OFF, 8'h80);
      wait_ev(1, 300, n);
      repeat (60) @(posedge clk);
      wr(`LPST_WKCON_OFF, 8'hC0);
      wait_ev(1, 200, n);
      chk(n > 120, 1, "wake clear ignored");
      rdchk(`LPST_WKCON_OFF, 8'hA0);
      wr(`LPST_WKCON_OFF, 8'h40);
      wr(`LPST_WKCON_OFF, 8'h00);
      wait_ev(1, 400, n);
      chk(n, 400, "disabled wake timer fired");
      @(posedge clk) cpu_power_down <= 1'b0;
      $display("test wake-up timer done");

      // retention across resets
      wr(`LPST_WDCTL_OFF, 8'h1D);
      wr(`LPST_WKCON_OFF, 8'h87);
      do_reset(1'b0, 1'b1);
      rdchk(`LPST_WDCTL_OFF, 8'h1D);
      rdchk(`LPST_WKCON_OFF, 8'h00);
      rdchk(`LPST_XIE_OFF, 8'h00);
      do_reset(1'b0, 1'b0);
      rdchk(`LPST_WDCTL_OFF, 8'h9D);
      do_reset(1'b1, 1'b0);
      rdchk(`LPST_WDCTL_OFF, 8'h80);
      $display("test resets done");
      summarize();
   end

endmodule : tb_top
